//--- rtl/can_mbx_cfg.svh
// register map, field positions and reset values of the mailbox block
//
// Operation
// [R1] A direction bit of 0 makes its mailbox transmit, 1 makes it receive.
// [R2] Bits 15..9 serve mailboxes 7..1 and bits 7..0 serve mailboxes 15..8.
// [R3] Direction bit 8 is read-only, resets to 1, reads 1; software writes 1.
// [R4] Software stores the message first and only then sets its wait bit.
// [R5] A wait bit written 1 puts that mailbox into the arbitration wait.
// [R6] A wait bit clears by itself once its message has been sent.
// [R7] A wait bit clears by itself once its cancellation has completed.
// [R8] A cancel bit written 1 withdraws that mailbox's waiting message.
// [R9] A cancel bit clears by itself once the matching wait bit is cleared.
// [R10] Cancel bit 8 is read-only and reads 0; software writes 0.
// [R11] The direction register is 16 bits and all mailbox bits reset to 0.
// [R12] A sent message sets its transmit ack flag; writing 1 clears it.
// [R13] A completed cancel sets its abort ack flag; writing 1 clears it.
// [R14] Writing 0 to a wait or cancel bit leaves that bit as it is.
// [R15] Only transmit mailboxes with their wait bit set join arbitration.
`ifndef CAN_MBX_CFG_SVH
`define CAN_MBX_CFG_SVH

`define REG_AW 3
`define ADDR_DIR 3'h0
`define ADDR_WAIT 3'h1
`define ADDR_CANCEL 3'h2
`define ADDR_TXACK 3'h3
`define ADDR_ABACK 3'h4
`define ADDR_ISTAT 3'h5
`define ADDR_IMASK 3'h6

`define RSV_BIT 8
`define DIR_RSV_VAL 1'h1
`define WAIT_RSV_VAL 1'h0
`define CANCEL_RSV_VAL 1'h0
`define ACK_RSV_VAL 1'h0

`define MBX_RST 15'h0000
`define WORD_ZERO 16'h0000
`define IRQ_W 2
`define IRQ_TX_BIT 0
`define IRQ_AB_BIT 1
`define IMASK_RST 2'h0
`define IRQ_ALL 2'h3

`endif

//--- rtl/can_mbx_pkg.sv
// types shared by the mailbox control modules
`include "can_mbx_cfg.svh"
package can_mbx_pkg;
  typedef logic [15:1] mbx_vec_t;
  typedef logic [15:0] reg_word_t;
  typedef logic [`REG_AW-1:0] reg_addr_t;
  typedef logic [`IRQ_W-1:0] irq_vec_t;
endpackage

//--- rtl/flag_if.sv
// set, clear and flag vectors of one sticky flag bank
`timescale 1ns/1ps
interface flag_if #(parameter int W = 15) ();
  logic [W-1:0] setVec;
  logic [W-1:0] clrVec;
  logic [W-1:0] flags;
  modport bank (input setVec, input clrVec, output flags);
  modport user (output setVec, output clrVec, input flags);
endinterface

//--- rtl/sticky_flag_bank.sv
// bank of sticky flags where a set beats a clear in the same cycle
`timescale 1ns/1ps
module sticky_flag_bank #(
  parameter int W = 15
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // flag vectors
  flag_if.bank fl
);
  logic [W-1:0] flagsQ;
  logic [W-1:0] flagsD;

  // an event landing on the clearing cycle must not be lost
  assign flagsD = (flagsQ & ~fl.clrVec) | fl.setVec;
  assign fl.flags = flagsQ;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flagsQ <= '0;
    end else begin
      flagsQ <= flagsD;
    end
  end
endmodule // sticky_flag_bank

//--- rtl/can_mailbox_tx_request_control.sv
// mailbox direction, transmit wait and cancel control with ack flags
`timescale 1ns/1ps
`include "can_mbx_cfg.svh"
module can_mailbox_tx_request_control (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // register port
  input wire can_mbx_pkg::reg_addr_t regAddr,
  input wire can_mbx_pkg::reg_word_t regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output can_mbx_pkg::reg_word_t regRdata,
  // protocol engine side
  input wire can_mbx_pkg::mbx_vec_t txDone,
  input wire can_mbx_pkg::mbx_vec_t abortDone,
  output can_mbx_pkg::mbx_vec_t arbReq,
  output can_mbx_pkg::mbx_vec_t cancelReq,
  // interrupt
  output logic irq
);
  import can_mbx_pkg::*;

  // byte-swapped mailbox order in every per-mailbox word
  function automatic reg_word_t toReg(input mbx_vec_t v, input logic rsv);
    toReg = {v[7:1], rsv, v[15:8]}; // R2
  endfunction

  function automatic mbx_vec_t fromReg(input reg_word_t w);
    fromReg = {w[7:0], w[15:9]}; // R2
  endfunction

  mbx_vec_t dirQ;
  mbx_vec_t dirD;
  mbx_vec_t waitQ;
  mbx_vec_t waitD;
  mbx_vec_t waitSet;
  mbx_vec_t cancelQ;
  mbx_vec_t cancelD;
  mbx_vec_t cancelSet;
  mbx_vec_t wrVec;
  mbx_vec_t arbD;
  mbx_vec_t arbReqQ;
  mbx_vec_t cancelReqQ;
  irq_vec_t imaskQ;
  irq_vec_t imaskD;
  irq_vec_t irqEvents;
  reg_word_t rdMux;
  reg_word_t rdataQ;
  reg_word_t rdataD;
  logic irqQ;
  logic irqD;
  logic wrDir;
  logic wrWait;
  logic wrCancel;
  logic wrTxAck;
  logic wrAbAck;
  logic wrImask;
  logic rdIstat;

  flag_if #(.W(15)) txAckIf ();
  flag_if #(.W(15)) abAckIf ();
  flag_if #(.W(`IRQ_W)) istatIf ();

  // address decode
  assign wrDir = regWr && (regAddr == `ADDR_DIR);
  assign wrWait = regWr && (regAddr == `ADDR_WAIT);
  assign wrCancel = regWr && (regAddr == `ADDR_CANCEL);
  assign wrTxAck = regWr && (regAddr == `ADDR_TXACK);
  assign wrAbAck = regWr && (regAddr == `ADDR_ABACK);
  assign wrImask = regWr && (regAddr == `ADDR_IMASK);
  assign rdIstat = regRd && (regAddr == `ADDR_ISTAT);
  assign wrVec = fromReg(regWdata);

  // direction bits, fully read/write; bit 8 is never stored
  assign dirD = wrDir ? wrVec : dirQ; // R1 R11

  // only ones take effect; zeros leave pending requests alone
  assign waitSet = wrWait ? wrVec : `MBX_RST; // R5 R14
  assign cancelSet = wrCancel ? wrVec : `MBX_RST; // R8 R14

  // a fresh request in the completion cycle starts a new wait
  assign waitD = (waitQ & ~(txDone | abortDone)) | waitSet; // R6 R7

  // cancel lives only while its wait bit does
  assign cancelD = (cancelQ | cancelSet) & waitD; // R9

  // withdrawn and receive mailboxes leave arbitration at once
  assign arbD = waitD & ~dirD & ~cancelD; // R15 R1 R8

  // ack flags and interrupt status
  assign txAckIf.setVec = txDone; // R12
  assign txAckIf.clrVec = wrTxAck ? wrVec : `MBX_RST; // R12
  assign abAckIf.setVec = abortDone; // R13
  assign abAckIf.clrVec = wrAbAck ? wrVec : `MBX_RST; // R13
  assign irqEvents[`IRQ_TX_BIT] = |txDone;
  assign irqEvents[`IRQ_AB_BIT] = |abortDone;
  assign istatIf.setVec = irqEvents;
  assign istatIf.clrVec = rdIstat ? `IRQ_ALL : `IMASK_RST;
  assign imaskD = wrImask ? regWdata[`IRQ_W-1:0] : imaskQ;
  assign irqD = |(istatIf.flags & imaskQ);

  // read selection; unmapped addresses read zero
  assign rdMux =
    (regAddr == `ADDR_DIR) ? toReg(dirQ, `DIR_RSV_VAL) : // R3
    (regAddr == `ADDR_WAIT) ? toReg(waitQ, `WAIT_RSV_VAL) :
    (regAddr == `ADDR_CANCEL) ? toReg(cancelQ, `CANCEL_RSV_VAL) : // R10
    (regAddr == `ADDR_TXACK) ? toReg(txAckIf.flags, `ACK_RSV_VAL) :
    (regAddr == `ADDR_ABACK) ? toReg(abAckIf.flags, `ACK_RSV_VAL) :
    (regAddr == `ADDR_ISTAT) ? {14'h0000, istatIf.flags} :
    (regAddr == `ADDR_IMASK) ? {14'h0000, imaskQ} :
    `WORD_ZERO;
  // data only in the cycle after the strobe, zero otherwise
  assign rdataD = regRd ? rdMux : `WORD_ZERO;

  sticky_flag_bank #(.W(15)) txAckBank (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .fl(txAckIf)
  );

  sticky_flag_bank #(.W(15)) abAckBank (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .fl(abAckIf)
  );

  sticky_flag_bank #(.W(`IRQ_W)) istatBank (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .fl(istatIf)
  );

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dirQ <= `MBX_RST; // R11
      waitQ <= `MBX_RST;
      cancelQ <= `MBX_RST;
    end else begin
      dirQ <= dirD;
      waitQ <= waitD;
      cancelQ <= cancelD;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      arbReqQ <= `MBX_RST;
      cancelReqQ <= `MBX_RST;
    end else begin
      arbReqQ <= arbD; // R5 R15
      cancelReqQ <= cancelD; // R8
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      imaskQ <= `IMASK_RST;
      irqQ <= 1'b0;
      rdataQ <= `WORD_ZERO;
    end else begin
      imaskQ <= imaskD;
      irqQ <= irqD;
      rdataQ <= rdataD;
    end
  end

  assign regRdata = rdataQ;
  assign arbReq = arbReqQ;
  assign cancelReq = cancelReqQ;
  assign irq = irqQ;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  property p_rxNeverArb;
    (arbReqQ & dirQ) == `MBX_RST;
  endproperty
  a_rxNeverArb: assert property (p_rxNeverArb) // R1
    else $error("receive mailbox requests arbitration");

  property p_waitMap;
    regRd && (regAddr == `ADDR_WAIT) |=>
      regRdata == {$past(waitQ[7:1]), 1'b0, $past(waitQ[15:8])};
  endproperty
  a_waitMap: assert property (p_waitMap) // R2
    else $error("wait word bit order wrong");

  property p_dirRsvOne;
    regRd && (regAddr == `ADDR_DIR) |=> regRdata[`RSV_BIT] == 1'b1;
  endproperty
  a_dirRsvOne: assert property (p_dirRsvOne) // R3
    else $error("direction bit 8 not read as one");

  property p_waitSet;
    wrWait |=> (waitQ & $past(wrVec)) == $past(wrVec);
  endproperty
  a_waitSet: assert property (p_waitSet) // R5
    else $error("written wait bit not set");

  property p_txClears;
    1'b1 |=> (waitQ & $past(txDone & ~waitSet)) == `MBX_RST;
  endproperty
  a_txClears: assert property (p_txClears) // R6
    else $error("wait bit kept after transmission");

  property p_abortClears;
    1'b1 |=> (waitQ & $past(abortDone & ~waitSet)) == `MBX_RST;
  endproperty
  a_abortClears: assert property (p_abortClears) // R7
    else $error("wait bit kept after cancellation");

  property p_cancelWithdraws;
    cancelReqQ == cancelQ && (arbReqQ & cancelQ) == `MBX_RST;
  endproperty
  a_cancelWithdraws: assert property (p_cancelWithdraws) // R8
    else $error("cancelled mailbox still arbitrating");

  property p_cancelNeedsWait;
    (cancelQ & ~waitQ) == `MBX_RST;
  endproperty
  a_cancelNeedsWait: assert property (p_cancelNeedsWait) // R9
    else $error("cancel bit outlives its wait bit");

  property p_cancelRsvZero;
    regRd && (regAddr == `ADDR_CANCEL) |=> regRdata[`RSV_BIT] == 1'b0;
  endproperty
  a_cancelRsvZero: assert property (p_cancelRsvZero) // R10
    else $error("cancel bit 8 not read as zero");

  property p_dirWrite;
    wrDir ##1 regRd && (regAddr == `ADDR_DIR) |=>
      regRdata == toReg($past(wrVec, 2), 1'b1);
  endproperty
  a_dirWrite: assert property (p_dirWrite) // R11
    else $error("direction readback differs from write");

  property p_txAckSet;
    1'b1 |=> ($past(txDone) & ~txAckIf.flags) == `MBX_RST;
  endproperty
  a_txAckSet: assert property (p_txAckSet) // R12
    else $error("transmit ack flag missed");

  property p_abAckSet;
    1'b1 |=> ($past(abortDone) & ~abAckIf.flags) == `MBX_RST;
  endproperty
  a_abAckSet: assert property (p_abAckSet) // R13
    else $error("abort ack flag missed");

  property p_zeroKeeps;
    wrWait |=> (~waitQ & $past(waitQ & ~(txDone | abortDone))) == `MBX_RST;
  endproperty
  a_zeroKeeps: assert property (p_zeroKeeps) // R14
    else $error("writing zero dropped a wait bit");

  property p_arbExact;
    arbReqQ == (waitQ & ~dirQ & ~cancelQ);
  endproperty
  a_arbExact: assert property (p_arbExact) // R15
    else $error("arbitration request mismatch");

  property p_irqFollows;
    1'b1 |=> irq == |$past(istatIf.flags & imaskQ);
  endproperty
  a_irqFollows: assert property (p_irqFollows)
    else $error("interrupt output wrong");

  property p_rdIdleZero;
    !regRd |=> regRdata == `WORD_ZERO;
  endproperty
  a_rdIdleZero: assert property (p_rdIdleZero)
    else $error("read data outside read slot");

  property p_dirKeep;
    !wrDir |=> $stable(dirQ);
  endproperty
  a_dirKeep: assert property (p_dirKeep) // R11
    else $error("direction changed without a write");

  property p_dirMap;
    regRd && (regAddr == `ADDR_DIR) |=>
      regRdata == toReg($past(dirQ), 1'b1);
  endproperty
  a_dirMap: assert property (p_dirMap) // R2
    else $error("direction word bit order wrong");

  property p_cancelMap;
    regRd && (regAddr == `ADDR_CANCEL) |=>
      regRdata == toReg($past(cancelQ), 1'b0);
  endproperty
  a_cancelMap: assert property (p_cancelMap) // R2
    else $error("cancel word bit order wrong");

  property p_waitRise;
    1'b1 |=> (waitQ & ~$past(waitQ | waitSet)) == `MBX_RST;
  endproperty
  a_waitRise: assert property (p_waitRise) // R5
    else $error("wait bit set without a write");

  property p_cancelRise;
    1'b1 |=> (cancelQ & ~$past(cancelQ | cancelSet)) == `MBX_RST;
  endproperty
  a_cancelRise: assert property (p_cancelRise) // R8
    else $error("cancel bit set without a write");

  property p_cancelTakes;
    wrCancel |=>
      (cancelReqQ & $past(wrVec & waitD)) == $past(wrVec & waitD);
  endproperty
  a_cancelTakes: assert property (p_cancelTakes) // R8
    else $error("written cancel bit not taken");

  property p_txAckClear;
    wrTxAck |=> (txAckIf.flags & $past(wrVec & ~txDone)) == `MBX_RST;
  endproperty
  a_txAckClear: assert property (p_txAckClear) // R12
    else $error("transmit ack flag not cleared");

  property p_abAckClear;
    wrAbAck |=> (abAckIf.flags & $past(wrVec & ~abortDone)) == `MBX_RST;
  endproperty
  a_abAckClear: assert property (p_abAckClear) // R13
    else $error("abort ack flag not cleared");

  property p_istatClear;
    rdIstat |=> (istatIf.flags & ~$past(irqEvents)) == `IMASK_RST;
  endproperty
  a_istatClear: assert property (p_istatClear)
    else $error("interrupt status not cleared by read");

  property p_cvTxDone;
    (arbReqQ != `MBX_RST) ##[1:50] (txDone != `MBX_RST);
  endproperty
  c_cvTxDone: cover property (p_cvTxDone);

  property p_cvCancel;
    (cancelQ != `MBX_RST) ##1 (cancelQ == `MBX_RST);
  endproperty
  c_cvCancel: cover property (p_cvCancel);

  property p_cvIrq;
    irq ##[1:20] !irq;
  endproperty
  c_cvIrq: cover property (p_cvIrq);

  property p_cvRdWait;
    wrWait ##1 regRd && (regAddr == `ADDR_WAIT);
  endproperty
  c_cvRdWait: cover property (p_cvRdWait);

endmodule // can_mailbox_tx_request_control

//--- dv/can_engine_model.sv
// protocol engine and bus model answering arbitration and cancel requests
`timescale 1ns/1ps
module can_engine_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // pace control from the bench
  input wire logic go,
  input wire logic slow,
  // request side
  input wire can_mbx_pkg::mbx_vec_t arbReq,
  input wire can_mbx_pkg::mbx_vec_t cancelReq,
  // completion pulses
  output can_mbx_pkg::mbx_vec_t txDone,
  output can_mbx_pkg::mbx_vec_t abortDone
);
  import can_mbx_pkg::*;
  logic [3:0] cnt_q;
  mbx_vec_t pick;
  // lowest pending mailbox wins; cancels go first
  assign pick = (|cancelReq) ? (cancelReq & (~cancelReq + 15'h0001))
                             : (arbReq & (~arbReq + 15'h0001));
  // prompt latency stays above 2 so a stale request never fires twice
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 4'h0;
      txDone <= '0;
      abortDone <= '0;
    end else begin
      txDone <= '0;
      abortDone <= '0;
      if (!go || (arbReq | cancelReq) == '0) begin
        cnt_q <= 4'h0;
      end else if (cnt_q < (slow ? 4'hB : 4'h3)) begin
        cnt_q <= cnt_q + 4'h1;
      end else begin
        cnt_q <= 4'h0;
        if (|cancelReq) begin
          abortDone <= pick;
        end else begin
          txDone <= pick;
        end
      end
    end
  end
endmodule // can_engine_model

//--- dv/testbench.sv
// self-checking bench of the mailbox request control block
`timescale 1ns/1ps
`include "can_mbx_cfg.svh"
module testbench;
  import can_mbx_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic go = 1'b0;
  logic slow = 1'b0;
  logic irq;
  reg_addr_t regAddr = '0;
  reg_word_t regWdata = '0;
  reg_word_t regRdata;
  mbx_vec_t txDone, abortDone, arbReq, cancelReq;
  int n_fail = 0;
  int n_checks = 0;

  can_mailbox_tx_request_control dut (.ref_clk(ref_clk), .rst_n(rst_n),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .txDone(txDone), .abortDone(abortDone),
    .arbReq(arbReq), .cancelReq(cancelReq), .irq(irq));
  can_engine_model eng (.ref_clk(ref_clk), .rst_n(rst_n), .go(go),
    .slow(slow), .arbReq(arbReq), .cancelReq(cancelReq), .txDone(txDone),
    .abortDone(abortDone));

  initial begin
    forever #20 ref_clk = ~ref_clk;
  end

  function automatic reg_word_t mb(input int n);
    return (n < 8) ? (16'h0001 << (n + 8)) : (16'h0001 << (n - 8));
  endfunction
  function automatic mbx_vec_t mv(input int n);
    return 15'h0001 << (n - 1);
  endfunction

  task automatic give_verdict;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chkw(input reg_word_t g, input reg_word_t e);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected at %0t: word %h want %h", $time, g, e);
    end
  endtask
  task automatic chkv(input mbx_vec_t g, input mbx_vec_t e);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected at %0t: vector %h want %h", $time, g, e);
    end
  endtask
  task automatic chkb(input logic g, input logic e);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected at %0t: irq %b want %b", $time, g, e);
    end
  endtask
  task automatic wr(input reg_addr_t a, input reg_word_t d);
    @(posedge ref_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input reg_addr_t a, input reg_word_t e);
    @(posedge ref_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1 chkw(regRdata, e);
  endtask
  // write then read with no gap, as the bus allows
  task automatic wrrd(input reg_addr_t a, input reg_word_t d,
                      input reg_word_t e);
    @(posedge ref_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
    regRd <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1 chkw(regRdata, e);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // bounded wait until the engine has nothing left to do
  task automatic drain;
    for (int i = 0; i < 300 && (arbReq | cancelReq) != '0; i++) begin
      @(posedge ref_clk);
    end
    settle(2);
  endtask

  initial begin
    repeat (5000) @(posedge ref_clk);
    n_fail++;
    give_verdict();
  end

  initial begin
    reg_word_t rstVal [8];
    rstVal = '{16'h0100, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0};
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (int a = 0; a < 8; a++) rd(a[2:0], rstVal[a]);
    wr(`ADDR_DIR, 16'h0100);
    rd(`ADDR_DIR, 16'h0100);
    wrrd(`ADDR_DIR, 16'hFFFF, 16'hFFFF);
    wr(`ADDR_DIR, mb(8) | 16'h0100);
    wr(`ADDR_WAIT, mb(1) | mb(15) | mb(8));
    settle(2);
    chkv(arbReq, mv(1) | mv(15));
    wr(`ADDR_CANCEL, 16'h0000);
    wrrd(`ADDR_WAIT, 16'h0000, mb(1) | mb(15) | mb(8));
    chkv(cancelReq, '0);
    go <= 1'b1;
    drain();
    rd(`ADDR_WAIT, mb(8));
    rd(`ADDR_TXACK, mb(1) | mb(15));
    chkb(irq, 1'b0);
    wr(`ADDR_IMASK, 16'h0001);
    settle(2);
    chkb(irq, 1'b1);
    rd(`ADDR_ISTAT, 16'h0001);
    settle(2);
    chkb(irq, 1'b0);
    wr(`ADDR_TXACK, mb(1));
    rd(`ADDR_TXACK, mb(15));
    // second round: cancel while slow, mailbox 8 now transmit
    go <= 1'b0;
    slow <= 1'b1;
    wr(`ADDR_DIR, 16'h0100);
    wr(`ADDR_WAIT, mb(3));
    wr(`ADDR_CANCEL, mb(3));
    wr(`ADDR_CANCEL, 16'h0000);
    settle(2);
    chkv(cancelReq, mv(3));
    chkv(arbReq, mv(8));
    rd(`ADDR_CANCEL, mb(3));
    go <= 1'b1;
    drain();
    rd(`ADDR_WAIT, 16'h0000);
    rd(`ADDR_CANCEL, 16'h0000);
    rd(`ADDR_ABACK, mb(3));
    rd(`ADDR_TXACK, mb(15) | mb(8));
    rd(`ADDR_ISTAT, 16'h0003);
    wr(`ADDR_ABACK, mb(3));
    rd(`ADDR_ABACK, 16'h0000);
    give_verdict();
  end
endmodule // testbench
